// *** rtl/lfocc_top.v ***
// lf oscillator control, calibration capture and external clock prescaler
`timescale 1ns/10ps
`include "lfocc_regs.vh"

// Behaviour
// - divider code 00/01/10/11 gives 8/4/2/1
// - enable bit 7 runs the oscillator
// - read-only ready flag bit 6 after stabilising
// - trim bits 5..2, 0000 fastest, 1111 slowest
// - timer2 captures falling, timer3 rising edge
// - capture copies count bytes into reload bytes
// - external clock divided by eight for peripherals
// - divided clock synchronised, jitter within half cycle
// - crystal mode claims input and output pins
// - rc, capacitor, cmos claim only output pin
module lfocc_top (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // special function register port
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    output reg  [7:0]  sfr_rdata_q,
    // analog lf oscillator
    input  wire        lf_osc_raw,
    output reg         lf_osc_enable_q,
    output reg  [3:0]  lf_osc_trim_q,
    output reg         lf_osc_div_clk_q,
    // timer 2 calibration capture
    input  wire        t2_lf_capture_mode,
    input  wire [7:0]  t2_timer_count_high,
    input  wire [7:0]  t2_timer_count_low,
    output reg  [7:0]  t2_timer_reload_high_q,
    output reg  [7:0]  t2_timer_reload_low_q,
    output reg         t2_capture_q,
    // timer 3 calibration capture
    input  wire        t3_lf_capture_mode,
    input  wire [7:0]  t3_timer_count_high,
    input  wire [7:0]  t3_timer_count_low,
    output reg  [7:0]  t3_timer_reload_high_q,
    output reg  [7:0]  t3_timer_reload_low_q,
    output reg         t3_capture_q,
    // external oscillator
    input  wire [2:0]  ext_osc_mode,
    input  wire        ext_osc_clk,
    output reg         osc_in_pin_claim_q,
    output reg         osc_out_pin_claim_q,
    output reg         ext_div8_tick_q,
    output reg         ext_div8_clk_q
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    reg        lf_osc_ready_q;      // frequency stabilised
    reg  [1:0] lf_osc_divider_sel_q; // divider code
    reg  [7:0] stable_cnt_q;        // edges seen since enable
    reg  [2:0] div_cnt_q;           // lf edges inside half period
    reg  [2:0] ext_cnt_q;           // external edges inside one tick

    wire       lf_level;            // synchronised lf oscillator
    wire       lf_rise;             // lf rising edge pulse
    wire       ext_rise;            // external rising edge pulse

    wire       ctrl_hit;            // port addresses the control register
    assign ctrl_hit = (sfr_addr == `LFOCC_CTRL_ADDR);

    // ------------------------------------------------------------
    // input synchronisers; both clocks arrive from outside the domain
    // ------------------------------------------------------------
    lfocc_sync u_lf_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (lf_osc_raw),
        .level    (lf_level),
        .rise     (lf_rise),
        .fall     ()
    );

    lfocc_sync u_ext_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (ext_osc_clk),
        .level    (),
        .rise     (ext_rise),
        .fall     ()
    );

    // ------------------------------------------------------------
    // control register writes; the ready bit ignores writes
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            lf_osc_enable_q      <= `LFOCC_EN_RST;
            lf_osc_trim_q        <= `LFOCC_TRIM_RST;
            lf_osc_divider_sel_q <= `LFOCC_DIV_RST;
        end else if (sfr_wr && ctrl_hit) begin
            lf_osc_enable_q      <= sfr_wdata[`LFOCC_EN_BIT];
            lf_osc_trim_q        <= sfr_wdata[`LFOCC_TRIM_HI:`LFOCC_TRIM_LO];
            lf_osc_divider_sel_q <= sfr_wdata[`LFOCC_DIV_HI:`LFOCC_DIV_LO];
        end
    end

    // ------------------------------------------------------------
    // register read; unmapped addresses read as zero
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_rd && ctrl_hit) begin
            sfr_rdata_q <= {lf_osc_enable_q, lf_osc_ready_q,
                            lf_osc_trim_q, lf_osc_divider_sel_q};
        end else if (sfr_rd) begin
            sfr_rdata_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // ready flag: counts oscillator edges after enable
    // ------------------------------------------------------------
    // edge count stands in for analog settling; a stopped oscillator
    // never reports ready, which is the safe failure
    always @(posedge clk) begin
        if (reset) begin
            stable_cnt_q   <= 8'h00;
            lf_osc_ready_q <= 1'b0;
        end else if (!lf_osc_enable_q) begin
            stable_cnt_q   <= 8'h00;
            lf_osc_ready_q <= 1'b0;
        end else if (lf_rise && !lf_osc_ready_q) begin
            if (stable_cnt_q == `LFOCC_STABLE_EDGES - 8'h01) begin
                lf_osc_ready_q <= 1'b1;
            end else begin
                stable_cnt_q <= stable_cnt_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // output divider: toggle every half period of lf rising edges
    // ------------------------------------------------------------
    reg  [2:0] half_last;           // last count of a half period
    always @* begin
        case (lf_osc_divider_sel_q)
            `LFOCC_DIV8: half_last = 3'h3;
            `LFOCC_DIV4: half_last = 3'h1;
            `LFOCC_DIV2: half_last = 3'h0;
            default:     half_last = 3'h0;
        endcase
    end

    reg        div_clk_d;           // next divided output level
    always @* begin
        div_clk_d = lf_osc_div_clk_q;
        if (!lf_osc_enable_q) begin
            div_clk_d = 1'b0;
        end else if (lf_osc_divider_sel_q == `LFOCC_DIV1) begin
            div_clk_d = lf_level;
        end else if (lf_rise && div_cnt_q == half_last) begin
            div_clk_d = ~lf_osc_div_clk_q;
        end
    end

    // half period counter and divided output flop
    always @(posedge clk) begin
        if (reset) begin
            div_cnt_q        <= 3'h0;
            lf_osc_div_clk_q <= 1'b0;
        end else begin
            lf_osc_div_clk_q <= div_clk_d;
            if (!lf_osc_enable_q) begin
                div_cnt_q <= 3'h0;
            end else if (lf_rise) begin
                if (div_cnt_q >= half_last) begin
                    div_cnt_q <= 3'h0;
                end else begin
                    div_cnt_q <= div_cnt_q + 3'h1;
                end
            end
        end
    end

    // edges of the divided output, seen one cycle before the flop moves
    wire       div_rise;            // divided output about to rise
    wire       div_fall;            // divided output about to fall
    assign div_rise = div_clk_d & ~lf_osc_div_clk_q;
    assign div_fall = ~div_clk_d & lf_osc_div_clk_q;

    // ------------------------------------------------------------
    // timer 2 capture on falling edge of the divided output
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            t2_timer_reload_high_q <= 8'h00;
            t2_timer_reload_low_q  <= 8'h00;
            t2_capture_q           <= 1'b0;
        end else begin
            t2_capture_q <= t2_lf_capture_mode & div_fall;
            if (t2_lf_capture_mode && div_fall) begin
                t2_timer_reload_high_q <= t2_timer_count_high;
                t2_timer_reload_low_q  <= t2_timer_count_low;
            end
        end
    end

    // ------------------------------------------------------------
    // timer 3 capture on rising edge of the divided output
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            t3_timer_reload_high_q <= 8'h00;
            t3_timer_reload_low_q  <= 8'h00;
            t3_capture_q           <= 1'b0;
        end else begin
            t3_capture_q <= t3_lf_capture_mode & div_rise;
            if (t3_lf_capture_mode && div_rise) begin
                t3_timer_reload_high_q <= t3_timer_count_high;
                t3_timer_reload_low_q  <= t3_timer_count_low;
            end
        end
    end

    // ------------------------------------------------------------
    // pin takeover by external oscillator mode
    // ------------------------------------------------------------
    reg        in_claim_d;          // input terminal pin claimed
    reg        out_claim_d;         // output terminal pin claimed
    always @* begin
        in_claim_d  = 1'b0;
        out_claim_d = 1'b0;
        case (ext_osc_mode)
            `LFOCC_XMODE_CMOS,
            `LFOCC_XMODE_CMOS2,
            `LFOCC_XMODE_RC,
            `LFOCC_XMODE_CAP: begin
                out_claim_d = 1'b1;
            end
            default: begin
                // both crystal codes 11x; off codes 00x claim nothing
                if ({ext_osc_mode[2:1], 1'b0} == `LFOCC_XMODE_XTAL) begin
                    in_claim_d  = 1'b1;
                    out_claim_d = 1'b1;
                end
            end
        endcase
    end

    // pin claim flops
    always @(posedge clk) begin
        if (reset) begin
            osc_in_pin_claim_q  <= 1'b0;
            osc_out_pin_claim_q <= 1'b0;
        end else begin
            osc_in_pin_claim_q  <= in_claim_d;
            osc_out_pin_claim_q <= out_claim_d;
        end
    end

    // ------------------------------------------------------------
    // external clock divide by eight, built on sampled edges
    // ------------------------------------------------------------
    // sampling only holds when the external clock stays well below
    // the system clock; faster clocks lose edges silently
    wire       ext_active;          // mode field says circuit is on
    assign ext_active = (ext_osc_mode[2:1] != 2'h0);

    always @(posedge clk) begin
        if (reset) begin
            ext_cnt_q       <= 3'h0;
            ext_div8_tick_q <= 1'b0;
            ext_div8_clk_q  <= 1'b0;
        end else begin
            ext_div8_tick_q <= 1'b0;
            if (!ext_active) begin
                ext_cnt_q      <= 3'h0;
                ext_div8_clk_q <= 1'b0;
            end else if (ext_rise) begin
                ext_cnt_q <= ext_cnt_q + 3'h1;
                if (ext_cnt_q == `LFOCC_EXT_DIV_LAST) begin
                    ext_div8_tick_q <= 1'b1;
                end
                if (ext_cnt_q[1:0] == 2'h3) begin
                    ext_div8_clk_q <= ~ext_div8_clk_q;
                end
            end
        end
    end

endmodule // lfocc_top

// *** inc/lfocc_regs.vh ***
// register map, field positions, reset values and counts of the lf oscillator control block
`ifndef LFOCC_REGS_VH
`define LFOCC_REGS_VH

// control register address on the special function register port
`define LFOCC_CTRL_ADDR      8'h86

// field positions in the control register
`define LFOCC_EN_BIT         7
`define LFOCC_RDY_BIT        6
`define LFOCC_TRIM_HI        5
`define LFOCC_TRIM_LO        2
`define LFOCC_DIV_HI         1
`define LFOCC_DIV_LO         0

// reset values
`define LFOCC_EN_RST         1'b0
`define LFOCC_TRIM_RST       4'h8
`define LFOCC_DIV_RST        2'h0

// divider select codes
`define LFOCC_DIV8           2'h0
`define LFOCC_DIV4           2'h1
`define LFOCC_DIV2           2'h2
`define LFOCC_DIV1           2'h3

// oscillator rising edges seen before the ready flag rises
`define LFOCC_STABLE_EDGES   8'h10

// external oscillator mode field codes (3 bits)
`define LFOCC_XMODE_CMOS     3'h2
`define LFOCC_XMODE_CMOS2    3'h3
`define LFOCC_XMODE_RC       3'h4
`define LFOCC_XMODE_CAP      3'h5
`define LFOCC_XMODE_XTAL     3'h6

// external clock prescale: last count of the eight rising edges that make one tick
`define LFOCC_EXT_DIV_LAST   3'h7

`endif

// *** rtl/lfocc_sync.v ***
// three-stage input synchroniser with edge pulses for pin-level clocks
`timescale 1ns/10ps

module lfocc_sync (
    // clock and reset
    input  wire clk,
    input  wire reset,
    // asynchronous input
    input  wire async_in,
    // synchronised outputs
    output wire level,
    output wire rise,
    output wire fall
);

    reg stage1_q;   // metastability catcher, read only by stage2
    reg stage2_q;   // first settled sample
    reg stage3_q;   // second settled sample
    reg level_q;    // accepted level, moves only on agreement

    // shift chain; a change counts once stage2 and stage3 agree
    always @(posedge clk) begin
        if (reset) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
            level_q  <= 1'b0;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            if (stage2_q == stage3_q) begin
                level_q <= stage3_q; // both settled samples agree
            end
        end
    end

    // edge pulses fire in the cycle the agreed level is about to move
    assign level = level_q;
    assign rise  = stage2_q & stage3_q & ~level_q;
    assign fall  = ~stage2_q & ~stage3_q & level_q;

endmodule // lfocc_sync

// *** sim/lfocc_far_model.sv ***
// far-side model: lf oscillator, timer time base, external clock
`timescale 1ns/10ps
module lfocc_far_model (
    // clock
    input  wire        clk,
    // run request from the block
    input  wire        osc_en,
    // model outputs
    output reg         lf_raw,
    output reg  [15:0] count,
    output reg         ext_clk
);
    reg [3:0] ph_q;  // free phase counter
    // known start, no unknowns reach the block
    initial begin
        ph_q = 4'h0;
        lf_raw = 1'b0;
        count = 16'h0;
        ext_clk = 1'b0;
    end
    // timer ticks each clock, so capture gaps read in clocks
    always @(posedge clk) begin
        ph_q <= ph_q + 4'h1;
        count <= count + 16'h1;
        ext_clk <= ph_q[2];
        lf_raw <= osc_en & ph_q[3];
    end
endmodule // lfocc_far_model

// *** sim/lfocc_properties.sv ***
// port checks of the lf oscillator control block
`timescale 1ns/10ps
`include "lfocc_regs.vh"
module lfocc_props (
    // clock and reset
    input wire       clk, reset,
    // register port
    input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata_q,
    input wire       sfr_wr, sfr_rd,
    // oscillator
    input wire       lf_osc_enable_q, lf_osc_div_clk_q,
    input wire [3:0] lf_osc_trim_q,
    // capture
    input wire       t2_lf_capture_mode, t2_capture_q, t3_lf_capture_mode, t3_capture_q,
    input wire [7:0] t2_timer_count_high, t2_timer_count_low,
    input wire [7:0] t2_timer_reload_high_q, t2_timer_reload_low_q,
    // external oscillator
    input wire [2:0] ext_osc_mode,
    input wire       osc_in_pin_claim_q, osc_out_pin_claim_q, ext_div8_tick_q, ext_div8_clk_q
);
    wire [1:0] mode_hi = ext_osc_mode[2:1];  // 00 means circuit off
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // access steps
    sequence s_wr; sfr_wr && sfr_addr == `LFOCC_CTRL_ADDR; endsequence
    sequence s_rd; sfr_rd && sfr_addr == `LFOCC_CTRL_ADDR; endsequence
    // margin for the ready and divider clear after disable
    sequence s_off; (!lf_osc_enable_q) [*3]; endsequence
    property p_wr_en; s_wr |=> lf_osc_enable_q == $past(sfr_wdata[7]); endproperty
    a_wr_en: assert property (p_wr_en) else $error("enable not written");
    property p_wr_trim; s_wr |=> lf_osc_trim_q == $past(sfr_wdata[5:2]); endproperty
    a_wr_trim: assert property (p_wr_trim) else $error("trim not written");
    property p_rd; s_rd |=> sfr_rdata_q[7] == $past(lf_osc_enable_q)
        && sfr_rdata_q[5:2] == $past(lf_osc_trim_q); endproperty
    a_rd: assert property (p_rd) else $error("control read wrong");
    property p_rdy_off; s_off ##0 s_rd |=> !sfr_rdata_q[6]; endproperty
    a_rdy_off: assert property (p_rdy_off) else $error("ready while off");
    property p_div_off; s_off |-> !lf_osc_div_clk_q; endproperty
    a_div_off: assert property (p_div_off) else $error("divider runs while off");
    property p_t2; t2_capture_q |-> $fell(lf_osc_div_clk_q) && $past(t2_lf_capture_mode);
    endproperty
    a_t2: assert property (p_t2) else $error("timer2 capture off a fall");
    property p_t3; $rose(lf_osc_div_clk_q) && $past(t3_lf_capture_mode) |-> t3_capture_q;
    endproperty
    a_t3: assert property (p_t3) else $error("timer3 capture missed");
    property p_cap; t2_capture_q |-> {t2_timer_reload_high_q, t2_timer_reload_low_q}
        == $past({t2_timer_count_high, t2_timer_count_low}); endproperty
    a_cap: assert property (p_cap) else $error("captured count wrong");
    property p_tick; ext_div8_tick_q |=> !ext_div8_tick_q [*8]; endproperty
    a_tick: assert property (p_tick) else $error("tick not single");
    property p_ext_off; (mode_hi == 2'h0) [*5] |-> !ext_div8_tick_q && !ext_div8_clk_q;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("ext clock while off");
    property p_pins; !$past(reset) |-> osc_in_pin_claim_q == &$past(mode_hi)
        && osc_out_pin_claim_q == |$past(mode_hi); endproperty
    a_pins: assert property (p_pins) else $error("pin claim wrong");
endmodule // lfocc_props

bind lfocc_top lfocc_props u_props (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .lf_osc_enable_q(lf_osc_enable_q), .lf_osc_div_clk_q(lf_osc_div_clk_q),
    .lf_osc_trim_q(lf_osc_trim_q), .t2_lf_capture_mode(t2_lf_capture_mode),
    .t2_capture_q(t2_capture_q), .t3_lf_capture_mode(t3_lf_capture_mode),
    .t3_capture_q(t3_capture_q), .t2_timer_count_high(t2_timer_count_high),
    .t2_timer_count_low(t2_timer_count_low), .t2_timer_reload_high_q(t2_timer_reload_high_q),
    .t2_timer_reload_low_q(t2_timer_reload_low_q), .ext_osc_mode(ext_osc_mode),
    .osc_in_pin_claim_q(osc_in_pin_claim_q), .osc_out_pin_claim_q(osc_out_pin_claim_q),
    .ext_div8_tick_q(ext_div8_tick_q), .ext_div8_clk_q(ext_div8_clk_q));

// *** sim/testbench.sv ***
// self-checking bench for the lf oscillator control block
`timescale 1ns/10ps
module testbench;
    reg         clk, reset, sfr_wr, sfr_rd, t2_mode, t3_mode;  // bench drives
    reg  [7:0]  sfr_addr, sfr_wdata;                           // register port
    reg  [2:0]  ext_mode;                                      // ext oscillator mode
    wire [7:0]  rdata, r2h, r2l, r3h, r3l;                     // read and reloads
    wire [15:0] count;                                         // timer time base
    wire [3:0]  trim;                                          // trim output
    wire        en, div_clk, cap2, cap3, raw, ext_clk, in_cl, out_cl, tick, ext8;
    integer     fail_count, n_tests, i, n;                     // counters
    reg  [15:0] c0, c1;                                        // capture values
    lfocc_far_model far (.clk(clk), .osc_en(en), .lf_raw(raw), .count(count),
        .ext_clk(ext_clk));
    lfocc_top dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_q(rdata), .lf_osc_raw(raw),
        .lf_osc_enable_q(en), .lf_osc_trim_q(trim), .lf_osc_div_clk_q(div_clk),
        .t2_lf_capture_mode(t2_mode), .t2_timer_count_high(count[15:8]),
        .t2_timer_count_low(count[7:0]), .t2_timer_reload_high_q(r2h),
        .t2_timer_reload_low_q(r2l), .t2_capture_q(cap2), .t3_lf_capture_mode(t3_mode),
        .t3_timer_count_high(count[15:8]), .t3_timer_count_low(count[7:0]),
        .t3_timer_reload_high_q(r3h), .t3_timer_reload_low_q(r3l), .t3_capture_q(cap3),
        .ext_osc_mode(ext_mode), .ext_osc_clk(ext_clk), .osc_in_pin_claim_q(in_cl),
        .osc_out_pin_claim_q(out_cl), .ext_div8_tick_q(tick), .ext_div8_clk_q(ext8));
    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // compare, four-state so unknowns fail
    task check(input [63:0] nm, input [15:0] exp, input [15:0] got);
    begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %0s exp %h got %h", nm, exp, got);
        end
    end
    endtask
    // one write strobe cycle
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    end
    endtask
    // read strobe, data lands one edge later
    task rd_chk(input [7:0] a, input [7:0] exp, input [63:0] nm);
    begin
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        check(nm, {8'h0, exp}, {8'h0, rdata});
    end
    endtask
    // bounded wait for a pulse: 0 timer2, 1 timer3, 2 ext tick
    task waitp(input [1:0] s, output [15:0] v);
    begin
        n = 0;
        @(negedge clk);
        while ((s == 2'h0 ? cap2 : s == 2'h1 ? cap3 : tick) !== 1'b1 && n < 300) begin
            @(negedge clk);
            n = n + 1;
        end
        if (n >= 300) begin
            fail_count = fail_count + 1;
            $display("unexpected pulse %0d exp seen got none", s);
        end
        v = s[0] ? {r3h, r3l} : {r2h, r2l};
    end
    endtask
    // verdict, the only exit
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // watchdog well past the expected few thousand cycles
    initial begin
        #80000;
        fail_count = fail_count + 1;
        $display("unexpected watchdog exp done got hang");
        stop_test;
    end
    // main sequence
    initial begin
        fail_count = 0;
        n_tests = 0;
        {reset, sfr_wr, sfr_rd, t2_mode, t3_mode} = 5'h10;
        {sfr_addr, sfr_wdata, ext_mode} = 19'h0;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        rd_chk(8'h86, 8'h20, "rst ctl");
        wr(8'h86, 8'hff);
        rd_chk(8'h86, 8'hbf, "ctl ff");
        check("trim", 16'hf, {12'h0, trim});
        wr(8'h87, 8'h00);
        rd_chk(8'h87, 8'h00, "unmapped");
        wr(8'h86, 8'h00);
        rd_chk(8'h86, 8'h00, "ctl 00");
        // ready only after the stabilising edges
        wr(8'h86, 8'h83);
        repeat (200) @(negedge clk);
        rd_chk(8'h86, 8'h83, "unready");
        repeat (80) @(negedge clk);
        rd_chk(8'h86, 8'hc3, "ready");
        // capture gap per divider code, falling then rising edges
        t2_mode = 1'b1;
        t3_mode = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h86, {6'h20, i[1:0]});
            waitp({1'b0, i[2]}, c0);
            waitp({1'b0, i[2]}, c0);
            waitp({1'b0, i[2]}, c1);
            check("gap", 16'h10 << (2'h3 - i[1:0]), c1 - c0);
        end
        // switching off a ready oscillator must drop the flag
        wr(8'h86, 8'h00);
        repeat (3) @(negedge clk);
        rd_chk(8'h86, 8'h00, "ctl off");
        // every mode code, pins then prescaler; mode chosen before use
        for (i = 0; i < 8; i = i + 1) begin
            ext_mode = i[2:0];
            repeat (3) @(negedge clk);
            check("in pin", {15'h0, i[2] & i[1]}, {15'h0, in_cl});
            check("out pin", {15'h0, i[2] | i[1]}, {15'h0, out_cl});
        end
        waitp(2'h2, c0);
        waitp(2'h2, c0);
        check("tick gap", 16'h40, n[15:0] + 16'h1);
        // square wave flips once per four rises, so 40 cycles sit 8 past the next flip
        c1 = {15'h0, ext8};
        repeat (40) @(negedge clk);
        check("ext clk", c1 ^ 16'h1, {15'h0, ext8});
        ext_mode = 3'h0;
        repeat (8) @(negedge clk);
        check("ext off", 16'h0, {14'h0, tick, ext8});
        stop_test;
    end
endmodule // testbench
